// ---- fsl_defs.vh ----
`ifndef FSL_DEFS_VH
`define FSL_DEFS_VH
// Register byte offsets
`define FSL_OFF_LIVE 5'h00
`define FSL_OFF_LAT1 5'h04
`define FSL_OFF_LAT2 5'h08
`define FSL_OFF_MASK 5'h0c
`define FSL_OFF_CTRL 5'h10
`define FSL_OFF_ISTAT 5'h14
// Widths and field layout
`define FSL_ALERT_W 7
`define FSL_FAST_W 3
`define FSL_IRQ_W 11
`define FSL_IRQ_FAST_LSB 8
`define FSL_BIT_UV 2
`define FSL_CTRL_PULSE 0
`define FSL_CTRL_LED_EN 1
`define FSL_CTRL_CONV2_EN 2
`define FSL_CTRL_W 3
// Reset values
`define FSL_RST_STAT 8'h00
`define FSL_RST_CTRL 3'h0
`define FSL_RST_IRQ 11'h000
// Interrupt pulse length in clock cycles
`define FSL_PULSE_CYCLES 4
`define FSL_PULSE_CW 8
`endif

// ---- fsl_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module fsl_host (
  input wire logic clock_in,
  input wire logic ack_in,
  input wire logic [31:0] dat_in,
  output logic cyc_out,
  output logic stb_out,
  output logic we_out,
  output logic [4:0] adr_out,
  output logic [3:0] sel_out,
  output logic [31:0] dat_out
);
  initial begin
    cyc_out = 1'h0;
    stb_out = 1'h0;
    we_out = 1'h0;
    adr_out = 5'h0;
    sel_out = 4'hf;
    dat_out = 32'h0;
  end
  // Request held whole until ack is seen; bound stops a dead slave
  task automatic xfer(input logic w, input logic [4:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic ok);
    int n;
    @(posedge clock_in);
    cyc_out <= 1'h1;
    stb_out <= 1'h1;
    we_out <= w;
    adr_out <= a;
    dat_out <= d;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (ack_in !== 1'h1 && n < 64);
    q = dat_in;
    ok = (ack_in === 1'h1);
    cyc_out <= 1'h0;
    stb_out <= 1'h0;
    dat_out <= ~d;
  endtask
endmodule // fsl_host
`default_nettype wire

// ---- fsl_rise_latch.v ----
`timescale 1ns/1ps
`default_nettype none
module fsl_rise_latch #(
  parameter W = 3
) (
  input wire clock_in,
  input wire sys_rst_in,
  input wire ce_in,
  input wire [W-1:0] level_in,
  input wire rd_clr_in,
  output wire [W-1:0] rise_out,
  output reg [W-1:0] latched_out
);
  reg [W-1:0] prev_q;
  wire [W-1:0] latched_d;

  assign rise_out = level_in & ~prev_q;
  // A rise in the clearing cycle survives the clear
  assign latched_d = (latched_out & ~{W{rd_clr_in}}) | rise_out;

  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      prev_q <= {W{1'b0}};
      latched_out <= {W{1'b0}};
    end else if (ce_in) begin
      prev_q <= level_in;
      latched_out <= latched_d;
    end
  end
endmodule // fsl_rise_latch
`default_nettype wire

// ---- fsl_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "fsl_defs.vh"
module fsl_top #(
  parameter PULSE_CYCLES = `FSL_PULSE_CYCLES
) (
  input wire clock_in,
  input wire sys_rst_in,
  input wire ce_in,
  // Wishbone classic slave
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [4:0] wb_adr_in,
  input wire [3:0] wb_sel_in,
  input wire [31:0] wb_dat_in,
  output reg [31:0] wb_dat_out,
  output reg wb_ack_out,
  // Comparator outputs
  input wire led_overcurrent_in,
  input wire led_switch_desaturation_in,
  input wire conv2_switch_desaturation_in,
  input wire chip_thermal_warning_in,
  input wire led_thermal_shutdown_in,
  input wire led_thermal_warning_in,
  input wire led_overvoltage_in,
  input wire led_uv_below_low_in,
  input wire led_uv_above_high_in,
  input wire conv2_overcurrent_in,
  input wire core_supply_overcurrent_in,
  // Power stage enables
  output wire led_drv_en_out,
  output wire conv2_en_out,
  // Interrupts
  output wire alert_irq_n_out,
  output wire irq_out
);
  // Counter width caps the pulse length; wider settings are cut on purpose
  localparam [`FSL_PULSE_CW-1:0] PULSE_LEN =
    PULSE_CYCLES[`FSL_PULSE_CW-1:0];

  reg [`FSL_FAST_W-1:0] live_q;
  reg led_undervoltage_q;
  reg [`FSL_CTRL_W-1:0] ctrl_q;
  reg [`FSL_IRQ_W-1:0] mask_q;
  reg [`FSL_IRQ_W-1:0] istat_q;
  reg [`FSL_IRQ_W-1:0] istat_d;
  reg pend_q;
  reg [`FSL_PULSE_CW-1:0] pulse_cnt_q;
  reg [31:0] rdata_d;
  reg [`FSL_IRQ_W-1:0] w1c_d;

  wire [`FSL_FAST_W-1:0] fast_now;
  wire [`FSL_ALERT_W-1:0] alert_now;
  wire [`FSL_FAST_W-1:0] fast_rise;
  wire [`FSL_ALERT_W-1:0] alert_rise;
  wire [`FSL_FAST_W-1:0] lat2_q;
  wire [`FSL_ALERT_W-1:0] lat1_q;
  wire [`FSL_IRQ_W-1:0] events;
  wire [`FSL_IRQ_W-1:0] irq_events;
  wire req;
  wire wr_req;
  wire rd_lat1;
  wire rd_lat2;
  wire led_trip;
  wire conv2_trip;
  wire pulse_mode;

  function sel_hit;
    input [4:0] adr;
    input [4:0] off;
    begin
      sel_hit = (adr[4:2] == off[4:2]);
    end
  endfunction

  assign req = wb_cyc_in & wb_stb_in & ~wb_ack_out & ce_in;
  assign wr_req = req & wb_we_in & wb_sel_in[0];
  // Reads clear on the edge that also captures the read data
  assign rd_lat1 = req & ~wb_we_in & sel_hit(wb_adr_in, `FSL_OFF_LAT1);
  assign rd_lat2 = req & ~wb_we_in & sel_hit(wb_adr_in, `FSL_OFF_LAT2);

  // Overcurrent comparator already applies the scaled current limit
  assign fast_now = {led_overcurrent_in, led_switch_desaturation_in,
                     conv2_switch_desaturation_in};
  assign alert_now = {chip_thermal_warning_in, led_thermal_shutdown_in,
                      led_thermal_warning_in, led_overvoltage_in,
                      led_undervoltage_q, conv2_overcurrent_in,
                      core_supply_overcurrent_in};

  // Hysteresis: between thresholds the level holds
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      led_undervoltage_q <= 1'b0;
    end else if (ce_in) begin
      if (led_uv_below_low_in) begin
        led_undervoltage_q <= 1'b1;
      end else if (led_uv_above_high_in) begin
        led_undervoltage_q <= 1'b0;
      end
    end
  end

  fsl_rise_latch #(
    .W(`FSL_ALERT_W)
  ) u_lat1 (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .level_in(alert_now),
    .rd_clr_in(rd_lat1),
    .rise_out(alert_rise),
    .latched_out(lat1_q)
  );

  fsl_rise_latch #(
    .W(`FSL_FAST_W)
  ) u_lat2 (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .ce_in(ce_in),
    .level_in(fast_now),
    .rd_clr_in(rd_lat2),
    .rise_out(fast_rise),
    .latched_out(lat2_q)
  );

  // Shutdown bypasses all clocked logic so it acts within the same cycle
  assign led_trip = led_overcurrent_in | led_switch_desaturation_in;
  assign conv2_trip = conv2_switch_desaturation_in;
  assign led_drv_en_out = ctrl_q[`FSL_CTRL_LED_EN] & ~led_trip;
  assign conv2_en_out = ctrl_q[`FSL_CTRL_CONV2_EN] & ~conv2_trip;
  assign pulse_mode = ctrl_q[`FSL_CTRL_PULSE];

  // Control: a trip also drops the stored enable so the stage stays off
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_q <= `FSL_RST_CTRL;
      mask_q <= `FSL_RST_IRQ;
    end else if (ce_in) begin
      if (wr_req && sel_hit(wb_adr_in, `FSL_OFF_CTRL)) begin
        ctrl_q <= wb_dat_in[`FSL_CTRL_W-1:0];
      end
      if (led_trip) begin
        ctrl_q[`FSL_CTRL_LED_EN] <= 1'b0;
      end
      if (conv2_trip) begin
        ctrl_q[`FSL_CTRL_CONV2_EN] <= 1'b0;
      end
      if (wr_req && sel_hit(wb_adr_in, `FSL_OFF_MASK)) begin
        mask_q <= {wb_dat_in[`FSL_IRQ_W-1:`FSL_IRQ_FAST_LSB], 1'b0,
                   wb_dat_in[`FSL_ALERT_W-1:0]};
      end
    end
  end

  // Interrupt status layout matches the mask; bit 7 is a gap
  assign events = {fast_rise, 1'b0, alert_rise};
  assign irq_events = events & mask_q;

  always @* begin
    w1c_d = {`FSL_IRQ_W{1'b0}};
    if (wr_req && sel_hit(wb_adr_in, `FSL_OFF_ISTAT)) begin
      w1c_d = wb_dat_in[`FSL_IRQ_W-1:0];
    end
    istat_d = (istat_q & ~w1c_d) | events;
  end

  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      istat_q <= `FSL_RST_IRQ;
    end else if (ce_in) begin
      istat_q <= istat_d;
    end
  end

  assign irq_out = |(istat_q & mask_q);

  // Level mode pending: cleared once latches are empty and both alert and fast inputs are gone
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pend_q <= 1'b0;
    end else if (ce_in) begin
      if (|irq_events) begin
        pend_q <= 1'b1;
      end else if (lat1_q == {`FSL_ALERT_W{1'b0}} &&
                   lat2_q == {`FSL_FAST_W{1'b0}} &&
                   alert_now == {`FSL_ALERT_W{1'b0}} &&
                   fast_now == {`FSL_FAST_W{1'b0}}) begin
        pend_q <= 1'b0;
      end
    end
  end

  // Pulse mode: an event during a pulse restarts it, so close events merge
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pulse_cnt_q <= {`FSL_PULSE_CW{1'b0}};
    end else if (ce_in) begin
      if (|irq_events) begin
        pulse_cnt_q <= PULSE_LEN;
      end else if (pulse_cnt_q != {`FSL_PULSE_CW{1'b0}}) begin
        pulse_cnt_q <= pulse_cnt_q - 1'b1;
      end
    end
  end

  assign alert_irq_n_out = pulse_mode ?
                           (pulse_cnt_q == {`FSL_PULSE_CW{1'b0}}) :
                           ~pend_q;

  // Read mux; unmapped offsets read zero
  always @* begin
    rdata_d = 32'h0000_0000;
    if (sel_hit(wb_adr_in, `FSL_OFF_LIVE)) begin
      rdata_d[`FSL_FAST_W-1:0] = live_q;
    end else if (sel_hit(wb_adr_in, `FSL_OFF_LAT1)) begin
      rdata_d[`FSL_ALERT_W-1:0] = lat1_q;
    end else if (sel_hit(wb_adr_in, `FSL_OFF_LAT2)) begin
      rdata_d[`FSL_FAST_W-1:0] = lat2_q;
    end else if (sel_hit(wb_adr_in, `FSL_OFF_MASK)) begin
      rdata_d[`FSL_IRQ_W-1:0] = mask_q;
    end else if (sel_hit(wb_adr_in, `FSL_OFF_CTRL)) begin
      rdata_d[`FSL_CTRL_W-1:0] = ctrl_q;
    end else if (sel_hit(wb_adr_in, `FSL_OFF_ISTAT)) begin
      rdata_d[`FSL_IRQ_W-1:0] = istat_q;
    end
  end

  // Live copy lags the pins by one cycle; short faults rely on the latches
  always @(posedge clock_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      live_q <= {`FSL_FAST_W{1'b0}};
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else if (ce_in) begin
      live_q <= fast_now;
      wb_ack_out <= req;
      if (req && !wb_we_in) begin
        wb_dat_out <= rdata_d;
      end
    end
  end
endmodule // fsl_top
`default_nettype wire

// ---- fsl_top_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fsl_defs.vh"
module fsl_chk #(parameter PULSE_CYCLES = 4) (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [4:0] wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic led_overcurrent_in,
  input wire logic led_switch_desaturation_in,
  input wire logic conv2_switch_desaturation_in,
  input wire logic led_drv_en_out,
  input wire logic conv2_en_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);
  wire rd = wb_ack_out && !wb_we_in;
  wire [2:0] ff = {led_overcurrent_in, led_switch_desaturation_in,
    conv2_switch_desaturation_in};
  trip_led_a: assert property ((ff[2] | ff[1]) |-> !led_drv_en_out)
    else $error("led driver on in fault");
  trip_conv2_a: assert property (ff[0] |-> !conv2_en_out)
    else $error("conv2 on in fault");
  req_ack_a: assert property (wb_cyc_in && wb_stb_in && ce_in && !wb_ack_out
    |=> wb_ack_out) else $error("no ack");
  ack_pulse_a: assert property (wb_ack_out && ce_in |=> !wb_ack_out)
    else $error("ack too long");
  live_read_a: assert property (rd && wb_adr_in == `FSL_OFF_LIVE
    |-> wb_dat_out == {29'h0, $past(ff, 2)}) else $error("live value");
  lat1_rsv_a: assert property (rd && wb_adr_in == `FSL_OFF_LAT1
    |-> wb_dat_out[31:7] == 25'h0) else $error("lat1 reserved");
  lat2_rsv_a: assert property (rd && wb_adr_in == `FSL_OFF_LAT2
    |-> wb_dat_out[31:3] == 29'h0) else $error("lat2 reserved");
  unmapped_read_a: assert property (rd && wb_adr_in[4:2] > 3'h5
    |-> wb_dat_out == 32'h0) else $error("unmapped read");
  fast_capture_a: assert property (rd && wb_adr_in == `FSL_OFF_LAT2
    && $past(ff[2], 3) && !$past(ff[2], 4) |-> wb_dat_out[2])
    else $error("overcurrent lost");
  cover property (rd && wb_adr_in == `FSL_OFF_LAT2 && wb_dat_out[2]);
  cover property ($fell(led_drv_en_out));
  cover property (wb_ack_out && wb_we_in);
endmodule // fsl_chk
bind fsl_top fsl_chk #(.PULSE_CYCLES(PULSE_CYCLES)) chk_u (.clock_in,
  .sys_rst_in, .ce_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
  .wb_dat_out, .wb_ack_out, .led_overcurrent_in, .led_switch_desaturation_in,
  .conv2_switch_desaturation_in, .led_drv_en_out, .conv2_en_out);
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "fsl_defs.vh"
module tb;
  localparam int PC = 4;
  logic clock_in = 1'h0;
  logic sys_rst_in = 1'h1;
  logic [6:0] al = 7'h0;
  logic [2:0] ff = 3'h0;
  logic uv_hi = 1'h0;
  logic ce = 1'h1;
  wire cyc, stb, we, ack, led_en, c2_en, irq_n, irq;
  wire [4:0] adr;
  wire [3:0] sel;
  wire [31:0] wd, rdat;
  int err_count = 0, n_compared = 0, seed = 32'h60a1f21f;
  int l1 = 0, l2 = 0, ist = 0, i, n;
  logic [31:0] p, q;
  logic ok;
  always #20 clock_in = ~clock_in;
  fsl_host host_u (.clock_in(clock_in), .ack_in(ack), .dat_in(rdat),
    .cyc_out(cyc), .stb_out(stb), .we_out(we), .adr_out(adr),
    .sel_out(sel), .dat_out(wd));
  fsl_top #(.PULSE_CYCLES(PC)) dut_u (.clock_in(clock_in),
    .sys_rst_in(sys_rst_in), .ce_in(ce), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wd),
    .wb_dat_out(rdat), .wb_ack_out(ack), .led_overcurrent_in(ff[2]),
    .led_switch_desaturation_in(ff[1]), .conv2_switch_desaturation_in(ff[0]),
    .chip_thermal_warning_in(al[6]), .led_thermal_shutdown_in(al[5]),
    .led_thermal_warning_in(al[4]), .led_overvoltage_in(al[3]),
    .led_uv_below_low_in(al[2]), .led_uv_above_high_in(uv_hi),
    .conv2_overcurrent_in(al[1]), .core_supply_overcurrent_in(al[0]),
    .led_drv_en_out(led_en), .conv2_en_out(c2_en),
    .alert_irq_n_out(irq_n), .irq_out(irq));
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    host_u.xfer(w, a, d, q, ok);
    if (!ok) begin
      err_count++;
      test_done;
    end
  endtask
  task rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask
  // One-cycle faults: the task drops them on the next edge, one cycle before the next read request
  task pulse(input logic [6:0] a, input logic [2:0] f);
    @(posedge clock_in);
    al <= a;
    ff <= f;
    uv_hi <= 1'h0;
    @(posedge clock_in);
    al <= 7'h0;
    ff <= 3'h0;
    uv_hi <= 1'h1;
    l1 = l1 | a;
    l2 = l2 | f;
    ist = ist | {f, 1'h0, a};
  endtask
  initial begin
    repeat (8) @(posedge clock_in);
    sys_rst_in <= 1'h0;
    for (i = 0; i < 8; i++) rd(5'(i * 4), 32'h0);
    for (i = 0; i < 3; i++) begin
      bus(1'h1, 5'(i * 4), 32'hff);
      rd(5'(i * 4), 32'h0);
    end
    bus(1'h1, `FSL_OFF_MASK, 32'h7ff);
    for (i = 0; i < 12; i++) begin
      bus(1'h1, `FSL_OFF_CTRL, 32'h6);
      chk("led_en", 32'h1, led_en);
      chk("c2_en", 32'h1, c2_en);
      p = $random(seed);
      pulse(p[6:0], p[9:7]);
      rd(`FSL_OFF_LAT2, l2);
      l2 = 0;
      if (l1 != 0) chk("irq_n", 32'h0, irq_n);
      rd(`FSL_OFF_LAT1, l1);
      l1 = 0;
      rd(`FSL_OFF_LAT1, 32'h0);
      repeat (2) @(posedge clock_in);
      chk("irq_n", 32'h1, irq_n);
      chk("irq", ist != 0, irq);
      chk("led_en", !(p[9] | p[8]), led_en);
      chk("c2_en", !p[7], c2_en);
      @(posedge clock_in);
      ff <= p[9:7];
      rd(`FSL_OFF_LIVE, p[9:7]);
      ff <= 3'h0;
      l2 = l2 | p[9:7];
      ist = ist | {p[9:7], 8'h0};
      rd(`FSL_OFF_ISTAT, ist);
      bus(1'h1, `FSL_OFF_ISTAT, 32'h7ff);
      ist = 0;
    end
    // Last live read left faults latched; clear so level mode can release
    rd(`FSL_OFF_LAT2, l2);
    l2 = 0;
    bus(1'h1, `FSL_OFF_MASK, 32'h0);
    pulse(7'h7f, 3'h7);
    repeat (4) @(posedge clock_in);
    chk("irq", 32'h0, irq);
    chk("irq_n", 32'h1, irq_n);
    rd(`FSL_OFF_LAT1, l1);
    rd(`FSL_OFF_LAT2, l2);
    l1 = 0;
    l2 = 0;
    rd(`FSL_OFF_ISTAT, ist);
    bus(1'h1, `FSL_OFF_ISTAT, 32'h7ff);
    bus(1'h1, `FSL_OFF_MASK, 32'h7ff);
    bus(1'h1, `FSL_OFF_CTRL, 32'h1);
    pulse(7'h1, 3'h0);
    n = 0;
    repeat (16) begin
      @(posedge clock_in);
      n += (irq_n === 1'h0);
    end
    chk("pulse", PC, n);
    // An alert that comes and goes while frozen must leave no trace
    @(posedge clock_in);
    ce <= 1'h0;
    al <= 7'h40;
    repeat (3) @(posedge clock_in);
    al <= 7'h0;
    @(posedge clock_in);
    ce <= 1'h1;
    rd(`FSL_OFF_LAT1, l1);
    test_done;
  end
endmodule // tb
`default_nettype wire
